// ### hw/sab_ctrl.sv
// Operation
// - Anti-stall on by pin or serial bit
// - Current steps down to floor; off means full
// - Config pins pass 0.625 us glitch filter
// - Pin floor decode 80..45 percent
// - Serial floor code 000..111 gives 80..45
// - Boost pin level gives 5,7,9,11 steps
// - Anti-stall suspended below step-rate limit
// - Limit doubles per finer step resolution
// - Serial frequency code 00..11, 11 off
// - Serial step rate from motor word writes
// - Faults encoded on two open-drain flags
// - Faults held until supply reapplied/standby
// - Standby stops oscillator and output stage
// - Forward current switch patterns per mode
// - Reverse current switch patterns per mode
// - Chopper sequences charge, fast, slow
// - Bank-low word initial, bank-high word motor
`include "sab_map.svh"
`default_nettype none
module sab_ctrl #(
  parameter int unsigned LIM_HI_CYC  = `SAB_CLK_HZ / `SAB_FREQ_FLOOR_PIN_HI_HZ,
  parameter int unsigned LIM_MID_CYC = `SAB_CLK_HZ / `SAB_FREQ_FLOOR_PIN_MID_HZ,
  parameter int unsigned LIM_LO_CYC  = `SAB_CLK_HZ / `SAB_FREQ_FLOOR_PIN_LO_HZ,
  parameter int unsigned CHOP_CYC    = 333,
  parameter int unsigned FAST_CYC    = 83,
  parameter int unsigned DEAD_CYC    = `SAB_DEAD_CYC
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          if_serial,
  input  wire logic          stby_n,
  input  wire logic          antistall_enable,
  input  wire logic          floor_sel_bit0,
  input  wire logic [1:0]    floor_sel_bit1,
  input  wire logic [1:0]    boost_level_pin,
  input  wire logic [1:0]    freq_floor_pin,
  input  wire logic          step_clk,
  input  wire logic          load_rising,
  input  wire logic [1:0]    coil_over,
  input  wire logic          motor_supply_ok,
  input  wire logic          thermal_trip,
  input  wire logic          overcurrent_trip,
  input  wire logic          open_load_trip,
  input  wire logic          fault_flag_a_i,
  input  wire logic          fault_flag_b_i,
  output logic               fault_flag_a_o,
  output logic               fault_flag_a_oe_n,
  output logic               fault_flag_b_o,
  output logic               fault_flag_b_oe_n,
  output logic               osc_run,
  output logic [6:0]         current_pct,
  output logic [1:0]         coil_pol,
  output sab_pkg::sab_gate_t gate_a,
  output sab_pkg::sab_gate_t gate_b
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [31:0]        cfg_r, cfg_nxt, mot_r, mot_nxt, ctrl_r, ctrl_nxt, rdata_r, rdata_nxt;
  logic               err_r, err_nxt, run_r, run_nxt, step_prev_r, supply_prev_r;
  logic [7:0]         pin_filt;
  sab_pkg::sab_cfg_t  cfg;
  logic [6:0]         floor_pct, pct_r, pct_nxt;
  logic [3:0]         boost_steps;
  logic [16:0]        per_r, per_nxt, lim;
  logic               below_r, below_nxt, step_evt, active, wr, hit;
  logic [2:0]         fault_r, fault_nxt;
  logic               fault_clr, chop_tick;
  logic [15:0]        chop_r, chop_nxt;
  logic [15:0]        fast_r [2], fast_nxt [2];
  sab_pkg::sab_mode_t mode_r [2], mode_nxt [2];

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  function automatic logic [6:0] floor_of(input logic [2:0] idx);
    floor_of = `SAB_FLOOR_TOP - 7'(`SAB_FLOOR_STEP * {4'h0, idx});
  endfunction : floor_of

  function automatic logic [16:0] limit_of(input logic [1:0] code, input logic [2:0] res);
    case (code)
      2'h0:    limit_of = 17'(LIM_HI_CYC >> res);
      2'h1:    limit_of = 17'(LIM_MID_CYC >> res);
      2'h2:    limit_of = 17'(LIM_LO_CYC >> res);
      default: limit_of = 17'h1FFFF;
    endcase
  endfunction : limit_of

  // ----------------------------------------
  // Pin filter and settings source
  // ----------------------------------------
  // Enable pin passes the glitch filter with the other pins; host keeps it steady while powered
  sab_glitch_filter #(
    .W   (8),
    .CYC (`SAB_GLITCH_CYC)
  ) u_filt (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .raw     ({antistall_enable, floor_sel_bit0, floor_sel_bit1, boost_level_pin, freq_floor_pin}),
    .filt    (pin_filt)
  );

  // Serial mode reads the bank-low word, clock mode the filtered pins
  always_comb begin
    if (if_serial) begin
      cfg.en         = cfg_r[`SAB_CFG_EN_BIT];
      cfg.floor_idx  = {cfg_r[`SAB_CFG_FLOOR_LSB], cfg_r[`SAB_CFG_FLOOR_LSB+1],
                        cfg_r[`SAB_CFG_FLOOR_LSB+2]};
      cfg.freq_code  = {cfg_r[`SAB_CFG_FREQ_LSB], cfg_r[`SAB_CFG_FREQ_LSB+1]};
      cfg.boost_code = {cfg_r[`SAB_CFG_BOOST_LSB], cfg_r[`SAB_CFG_BOOST_LSB+1]};
    end else begin
      cfg.en         = pin_filt[7];
      cfg.floor_idx  = {~pin_filt[6], pin_filt[5:4]};
      cfg.freq_code  = pin_filt[1:0];
      cfg.boost_code = pin_filt[3:2];
    end
  end

  assign floor_pct   = floor_of(cfg.floor_idx);
  assign boost_steps = `SAB_BOOST_BASE + {1'b0, cfg.boost_code, 1'b0};
  assign lim         = limit_of(cfg.freq_code, ctrl_r[`SAB_CTRL_RES_LSB +: 3]);

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign wr  = psel & penable & pwrite;
  assign hit = (paddr == `SAB_REG_CFG) || (paddr == `SAB_REG_MOTOR) ||
               (paddr == `SAB_REG_STATUS) || (paddr == `SAB_REG_CTRL);

  // Read data and error are captured in setup so they leave a flop
  always_comb begin
    cfg_nxt   = cfg_r;
    mot_nxt   = mot_r;
    ctrl_nxt  = ctrl_r;
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    if (psel && !penable) begin
      err_nxt = !hit;
      case (paddr)
        `SAB_REG_CFG:    rdata_nxt = cfg_r;
        `SAB_REG_MOTOR:  rdata_nxt = mot_r;
        `SAB_REG_STATUS: rdata_nxt = {7'h00, boost_steps, floor_pct, pct_r, below_r, active,
                                      fault_flag_b_i, fault_flag_a_i, fault_r};
        `SAB_REG_CTRL:   rdata_nxt = ctrl_r;
        default:         rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      case (paddr)
        `SAB_REG_CFG:   cfg_nxt = pwdata;
        `SAB_REG_MOTOR: mot_nxt = pwdata;
        `SAB_REG_CTRL:  ctrl_nxt = {28'h0000000, pwdata[3:0]};
        default:        cfg_nxt = cfg_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r   <= `SAB_CFG_RST;
      mot_r   <= `SAB_MOT_RST;
      ctrl_r  <= `SAB_CTRL_RST;
      rdata_r <= 32'h0000_0000;
      err_r   <= 1'b0;
    end else begin
      cfg_r   <= cfg_nxt;
      mot_r   <= mot_nxt;
      ctrl_r  <= ctrl_nxt;
      rdata_r <= rdata_nxt;
      err_r   <= err_nxt;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = rdata_r;
  assign pslverr = psel & penable & err_r;

  // ----------------------------------------
  // Step rate and anti-stall current
  // ----------------------------------------
  // Serial mode counts motor word writes as steps
  assign step_evt = if_serial ? (wr && paddr == `SAB_REG_MOTOR) : (step_clk & ~step_prev_r);
  assign active   = cfg.en & ~below_r & run_r;

  // Period counter saturates; a slow rate also shows before the next step
  always_comb begin
    per_nxt   = (per_r == 17'h1FFFF) ? per_r : per_r + 17'h00001;
    below_nxt = below_r;
    if (cfg.freq_code == `SAB_FREQ_OFF) begin
      below_nxt = 1'b0;
    end else if (step_evt) begin
      below_nxt = (per_r >= lim);
    end else if (per_r >= lim) begin
      below_nxt = 1'b1;
    end
    if (step_evt) begin
      per_nxt = 17'h00000;
    end
    pct_nxt = pct_r;
    if (!active) begin
      pct_nxt = `SAB_FULL_PCT;
    end else if (step_evt) begin
      if (load_rising) begin
        pct_nxt = ({1'b0, pct_r} + {4'h0, boost_steps} > {1'b0, `SAB_FULL_PCT}) ?
                  `SAB_FULL_PCT : pct_r + {3'h0, boost_steps};
      end else if (pct_r > floor_pct) begin
        pct_nxt = pct_r - 7'h01;
      end else begin
        pct_nxt = floor_pct;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      per_r       <= 17'h00000;
      below_r     <= 1'b0;
      pct_r       <= `SAB_FULL_PCT;
      step_prev_r <= 1'b0;
    end else begin
      per_r       <= per_nxt;
      below_r     <= below_nxt;
      pct_r       <= pct_nxt;
      step_prev_r <= step_clk;
    end
  end

  assign current_pct = pct_r;
  assign coil_pol    = {mot_r[`SAB_MOT_PHB_BIT], mot_r[`SAB_MOT_PHA_BIT]};

  // ----------------------------------------
  // Fault latch, flags and standby
  // ----------------------------------------
  assign fault_clr = ~stby_n | (motor_supply_ok & ~supply_prev_r);
  assign run_nxt   = stby_n;

  // A trip in the clearing cycle still latches
  always_comb begin
    fault_nxt = (fault_clr ? 3'h0 : fault_r) | {open_load_trip, overcurrent_trip, thermal_trip};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fault_r       <= 3'h0;
      supply_prev_r <= 1'b0;
      run_r         <= 1'b0;
    end else begin
      fault_r       <= fault_nxt;
      supply_prev_r <= motor_supply_ok;
      run_r         <= run_nxt;
    end
  end

  // Thermal wins over overcurrent, which wins over open load
  assign fault_flag_a_o    = 1'b0;
  assign fault_flag_b_o    = 1'b0;
  assign fault_flag_a_oe_n = ~(fault_r[0] | fault_r[1]);
  assign fault_flag_b_oe_n = ~(fault_r[0] | (fault_r[2] & ~fault_r[1]));
  assign osc_run           = run_r;

  // ----------------------------------------
  // Chopper per coil
  // ----------------------------------------
  assign chop_tick = (chop_r >= 16'(CHOP_CYC - 1));
  assign chop_nxt  = (chop_tick || !run_r) ? 16'h0000 : chop_r + 16'h0001;

  // Charge until over target, fast for a fixed time, slow until next period
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      mode_nxt[i] = mode_r[i];
      fast_nxt[i] = fast_r[i];
      if (!run_r) begin
        mode_nxt[i] = sab_pkg::SAB_CHARGE;
        fast_nxt[i] = 16'h0000;
      end else begin
        case (mode_r[i])
          sab_pkg::SAB_CHARGE: begin
            if (coil_over[i]) begin
              mode_nxt[i] = sab_pkg::SAB_FAST;
              fast_nxt[i] = 16'h0000;
            end
          end
          sab_pkg::SAB_FAST: begin
            if (fast_r[i] >= 16'(FAST_CYC - 1)) begin
              mode_nxt[i] = sab_pkg::SAB_SLOW;
            end else begin
              fast_nxt[i] = fast_r[i] + 16'h0001;
            end
          end
          sab_pkg::SAB_SLOW: begin
            if (chop_tick) begin
              mode_nxt[i] = sab_pkg::SAB_CHARGE;
            end
          end
          default: mode_nxt[i] = sab_pkg::SAB_CHARGE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chop_r <= 16'h0000;
      for (int i = 0; i < 2; i++) begin
        mode_r[i] <= sab_pkg::SAB_CHARGE;
        fast_r[i] <= 16'h0000;
      end
    end else begin
      chop_r <= chop_nxt;
      for (int i = 0; i < 2; i++) begin
        mode_r[i] <= mode_nxt[i];
        fast_r[i] <= fast_nxt[i];
      end
    end
  end

  // ----------------------------------------
  // Bridges: off in standby or on thermal/overcurrent
  // ----------------------------------------
  logic drv_en;
  assign drv_en = run_r & ctrl_r[`SAB_CTRL_DRV_BIT] & ~fault_r[0] & ~fault_r[1];

  sab_bridge_leg #(.DEAD_CYC (DEAD_CYC)) u_br_a (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .en      (drv_en),
    .pol     (coil_pol[0]),
    .mode    (mode_r[0]),
    .gate    (gate_a)
  );

  sab_bridge_leg #(.DEAD_CYC (DEAD_CYC)) u_br_b (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .en      (drv_en),
    .pol     (coil_pol[1]),
    .mode    (mode_r[1]),
    .gate    (gate_b)
  );
endmodule : sab_ctrl
`default_nettype wire

// ### hw/sab_map.svh
`ifndef SAB_MAP_SVH
`define SAB_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SAB_REG_CFG      8'h00
`define SAB_REG_MOTOR    8'h04
`define SAB_REG_STATUS   8'h08
`define SAB_REG_CTRL     8'h0C
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SAB_CFG_EN_BIT   2
`define SAB_CFG_FLOOR_LSB 3
`define SAB_CFG_FREQ_LSB 6
`define SAB_CFG_BOOST_LSB 8
`define SAB_MOT_PHA_BIT  8
`define SAB_MOT_CA_LSB   9
`define SAB_MOT_PHB_BIT  21
`define SAB_MOT_CB_LSB   22
`define SAB_CTRL_RES_LSB 0
`define SAB_CTRL_DRV_BIT 3
// ----------------------------------------
// Reset values and decode constants
// ----------------------------------------
`define SAB_CFG_RST      32'h0000_0000
`define SAB_MOT_RST      32'h0000_0000
`define SAB_CTRL_RST     32'h0000_0000
`define SAB_FULL_PCT     7'h64
`define SAB_FLOOR_TOP    7'h50
`define SAB_FLOOR_STEP   7'h05
`define SAB_BOOST_BASE   4'h5
`define SAB_FREQ_OFF     2'h3
// ----------------------------------------
// Timing
// ----------------------------------------
`define SAB_CLK_NS       40
`define SAB_CLK_HZ       25000000
`define SAB_GLITCH_NS    625
`define SAB_GLITCH_CYC   ((`SAB_GLITCH_NS + `SAB_CLK_NS - 1) / `SAB_CLK_NS)
`define SAB_DEAD_NS      200
`define SAB_DEAD_CYC     ((`SAB_DEAD_NS + `SAB_CLK_NS - 1) / `SAB_CLK_NS)
`define SAB_FREQ_FLOOR_PIN_HI_HZ   675
`define SAB_FREQ_FLOOR_PIN_MID_HZ  450
`define SAB_FREQ_FLOOR_PIN_LO_HZ   225
`endif

// ### hw/sab_pkg.sv
`default_nettype none
package sab_pkg;
  // Bridge modes of one coil
  typedef enum logic [1:0] {SAB_CHARGE, SAB_SLOW, SAB_FAST} sab_mode_t;
  // Four switches of one H-bridge
  typedef struct packed {
    logic high_side_one;
    logic high_side_two;
    logic low_side_one;
    logic low_side_two;
  } sab_gate_t;
  // Decoded anti-stall settings
  typedef struct packed {
    logic       en;
    logic [2:0] floor_idx;
    logic [1:0] freq_code;
    logic [1:0] boost_code;
  } sab_cfg_t;
endpackage : sab_pkg
`default_nettype wire

// ### hw/sab_glitch_filter.sv
`default_nettype none
module sab_glitch_filter #(
  parameter int unsigned W   = 8,
  parameter int unsigned CYC = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] raw,
  output logic [W-1:0]      filt
);
  logic [W-1:0] prev_r, prev_nxt, filt_r, filt_nxt;
  logic [7:0]   cnt_r, cnt_nxt;

  // Output follows only after the raw value held still for CYC cycles
  always_comb begin
    prev_nxt = raw;
    filt_nxt = filt_r;
    cnt_nxt  = 8'h00;
    if (raw == prev_r && raw != filt_r) begin
      if (cnt_r >= 8'(CYC - 1)) begin
        filt_nxt = raw;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= '0;
      filt_r <= '0;
      cnt_r  <= 8'h00;
    end else begin
      prev_r <= prev_nxt;
      filt_r <= filt_nxt;
      cnt_r  <= cnt_nxt;
    end
  end

  assign filt = filt_r;
endmodule : sab_glitch_filter
`default_nettype wire

// ### hw/sab_bridge_leg.sv
`default_nettype none
module sab_bridge_leg #(
  parameter int unsigned DEAD_CYC = 5
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                en,
  input  wire logic                pol,
  input  wire sab_pkg::sab_mode_t  mode,
  output sab_pkg::sab_gate_t       gate
);
  sab_pkg::sab_gate_t gate_r, gate_nxt, target;
  logic [7:0]         dead_r, dead_nxt;

  // Switch pattern per mode and current direction
  function automatic sab_pkg::sab_gate_t pattern(input sab_pkg::sab_mode_t m, input logic fwd);
    case (m)
      sab_pkg::SAB_CHARGE: pattern = fwd ? 4'b1001 : 4'b0110;
      sab_pkg::SAB_FAST:   pattern = fwd ? 4'b0110 : 4'b1001;
      default:             pattern = 4'b0011;
    endcase
  endfunction : pattern

  assign target = en ? pattern(mode, pol) : 4'b0000;

  // Every change passes through all-off for the dead time
  always_comb begin
    gate_nxt = gate_r;
    dead_nxt = dead_r;
    if (target != gate_r) begin
      if (gate_r != 4'b0000) begin
        gate_nxt = 4'b0000;
        dead_nxt = 8'(DEAD_CYC);
      end else if (dead_r != 8'h00) begin
        dead_nxt = dead_r - 8'h01;
      end else begin
        gate_nxt = target;
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gate_r <= 4'b0000;
      dead_r <= 8'h00;
    end else begin
      gate_r <= gate_nxt;
      dead_r <= dead_nxt;
    end
  end

  assign gate = gate_r;
endmodule : sab_bridge_leg
`default_nettype wire

// ### test/sab_ctrl_sva.sv
`default_nettype none
module sab_ctrl_sva (
  input wire logic               clk_sys,
  input wire logic               rst_n,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic [7:0]         paddr,
  input wire logic               pslverr,
  input wire logic               stby_n,
  input wire logic               thermal_trip,
  input wire logic               overcurrent_trip,
  input wire logic               open_load_trip,
  input wire logic               fault_flag_a_oe_n,
  input wire logic               fault_flag_b_oe_n,
  input wire logic               osc_run,
  input wire logic [6:0]         current_pct,
  input wire sab_pkg::sab_gate_t gate_a,
  input wire sab_pkg::sab_gate_t gate_b
);
  // ----------------------------------------
  // Properties, one clock domain
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Bridge left on, then all-off: dead gap must follow
  sequence s_a_off; (gate_a != 4'h0) ##1 (gate_a == 4'h0); endsequence
  sequence s_stby; (!stby_n) [*3]; endsequence
  property p_legal_a; gate_a inside {4'h0, 4'h9, 4'h6, 4'h3}; endproperty
  property p_legal_b; gate_b inside {4'h0, 4'h9, 4'h6, 4'h3}; endproperty
  property p_dead_a; s_a_off |-> (gate_a == 4'h0) [*5]; endproperty
  property p_thermal; thermal_trip |-> ##[1:2] (!fault_flag_a_oe_n && !fault_flag_b_oe_n); endproperty
  property p_overc; overcurrent_trip |-> ##[1:2] !fault_flag_a_oe_n; endproperty
  // Earlier overcurrent masks the open-load flag, so it is excluded
  property p_open; (open_load_trip && !overcurrent_trip && !thermal_trip && fault_flag_a_oe_n
    && !$past(overcurrent_trip)) |-> ##[1:2] !fault_flag_b_oe_n; endproperty
  property p_clear; (!stby_n && !thermal_trip && !overcurrent_trip && !open_load_trip) [*3]
    |-> (fault_flag_a_oe_n && fault_flag_b_oe_n); endproperty
  property p_stby; s_stby |-> (!osc_run && gate_a == 4'h0 && gate_b == 4'h0); endproperty
  property p_unmapped; (psel && penable && paddr > 8'h0C) |-> pslverr; endproperty
  property p_pct; current_pct inside {[7'h2D:7'h64]}; endproperty
  a_legal_a: assert property (p_legal_a) else $error("gate_a pattern not allowed");
  a_legal_b: assert property (p_legal_b) else $error("gate_b pattern not allowed");
  a_dead_a: assert property (p_dead_a) else $error("gate_a dead gap too short");
  a_thermal: assert property (p_thermal) else $error("thermal flags missing");
  a_overc: assert property (p_overc) else $error("overcurrent flag missing");
  a_open: assert property (p_open) else $error("open load flag missing");
  a_clear: assert property (p_clear) else $error("flags not released in standby");
  a_stby: assert property (p_stby) else $error("output stage alive in standby");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_pct: assert property (p_pct) else $error("current percent out of range");
endmodule : sab_ctrl_sva
bind sab_ctrl sab_ctrl_sva i_sva (.*);
`default_nettype wire

// ### test/sab_coil_model.sv
`default_nettype none
module sab_coil_model #(
  parameter int TH = 8
) (
  input wire logic               clk_sys,
  input wire sab_pkg::sab_gate_t gate_a,
  input wire sab_pkg::sab_gate_t gate_b,
  input wire logic [1:0]         coil_pol,
  input wire logic               fault_flag_a_o,
  input wire logic               fault_flag_a_oe_n,
  input wire logic               fault_flag_b_o,
  input wire logic               fault_flag_b_oe_n,
  output logic [1:0]             coil_over,
  output logic                   fault_flag_a_i,
  output logic                   fault_flag_b_i
);
  // ----------------------------------------
  // Coil current and flag pins
  // ----------------------------------------
  int coil_i [2] = '{0, 0};
  // Plus drive raises, minus lowers; off and recirculation hold the current
  function automatic int drift(input int i, input sab_pkg::sab_gate_t g);
    return i + int'(g == 4'h9) - int'(g == 4'h6);
  endfunction : drift
  always @(posedge clk_sys) begin
    coil_i[0] <= drift(coil_i[0], gate_a);
    coil_i[1] <= drift(coil_i[1], gate_b);
  end
  // Over only in the commanded direction: a wrong pattern never trips it
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      coil_over[k] = coil_pol[k] ? (coil_i[k] > TH) : (coil_i[k] < -TH);
    end
  end
  // Pull-ups on the released open-drain flags
  assign fault_flag_a_i = fault_flag_a_oe_n ? 1'b1 : fault_flag_a_o;
  assign fault_flag_b_i = fault_flag_b_oe_n ? 1'b1 : fault_flag_b_o;
endmodule : sab_coil_model
`default_nettype wire

// ### test/testbench.sv
`include "sab_map.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0, prdata, rd;
  logic               pready, pslverr, er, osc_run, fault_flag_a_i, fault_flag_b_i;
  logic               if_serial = 1'b1, stby_n = 1'b1, floor_sel_bit0 = 1'b0, step_clk = 1'b0;
  logic               antistall_enable = 1'b1; // Changed only while held in reset
  logic               load_rising = 1'b0, motor_supply_ok = 1'b1;
  logic               thermal_trip = 1'b0, overcurrent_trip = 1'b0, open_load_trip = 1'b0;
  logic [1:0]         floor_sel_bit1 = 2'h0, boost_level_pin = 2'h0, freq_floor_pin = 2'h3;
  logic [1:0]         coil_over, coil_pol;
  logic               fault_flag_a_o, fault_flag_a_oe_n, fault_flag_b_o, fault_flag_b_oe_n;
  logic [6:0]         current_pct;
  sab_pkg::sab_gate_t gate_a, gate_b;
  int                 n_mismatch = 0, n_compared = 0, cyc = 0, per;
  int                 lims [4] = '{400, 300, 200, 400};
  always #20 clk_sys = ~clk_sys;
  // Fast phase outlasts the dead gap so the fast pattern is really driven
  sab_ctrl #(.LIM_HI_CYC(400), .LIM_MID_CYC(300), .LIM_LO_CYC(200), .CHOP_CYC(20), .FAST_CYC(8),
    .DEAD_CYC(5)) i_dut (.*);
  sab_coil_model i_coil (.*);
  // ----------------------------------------
  // Bus, compare and stimulus tasks
  // ----------------------------------------
  task give_verdict;
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // Hang guard, nearly four times the expected run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 50000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Request held until pready seen high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys); penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata; er = pslverr; psel <= 1'b0; penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask : rdc
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  task step(input int n, input int p);
    repeat (n) begin
      step_clk <= 1'b1; wt(2); step_clk <= 1'b0; wt(p - 2);
    end
  endtask : step
  task seen(input logic [3:0] pat);
    for (int k = 0; k < 200 && gate_a !== pat; k++) @(posedge clk_sys);
    chk({28'h0, gate_a}, {28'h0, pat});
  endtask : seen
  // Trip briefly, confirm hold, then clear by standby or supply return
  task fault(input int kind, input logic [1:0] exp, input logic by_stby);
    thermal_trip <= (kind == 0); overcurrent_trip <= (kind == 1); open_load_trip <= (kind == 2); wt(3);
    thermal_trip <= 1'b0; overcurrent_trip <= 1'b0; open_load_trip <= 1'b0; wt(5);
    chk({30'h0, fault_flag_a_i, fault_flag_b_i}, {30'h0, exp});
    if (by_stby) stby_n <= 1'b0;
    else motor_supply_ok <= 1'b0;
    wt(8); stby_n <= 1'b1; motor_supply_ok <= 1'b1; wt(3);
    chk({30'h0, fault_flag_a_i, fault_flag_b_i}, 32'h3);
  endtask : fault
  function automatic logic [31:0] cfgw(input logic e, input logic [2:0] f, input logic [1:0] q,
                                       input logic [1:0] b);
    return {22'h0, b[0], b[1], q[0], q[1], f[0], f[1], f[2], e, 2'h0};
  endfunction : cfgw
  function automatic logic [31:0] stx(input int f, input int b);
    return {7'h0, 4'(b), 7'(f), 14'h0};
  endfunction : stx
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    wt(3); rst_n <= 1'b1; wt(1);
    rdc(`SAB_REG_CFG, 32'hFFFF_FFFF, 32'h0);
    rdc(8'h10, 32'hFFFF_FFFF, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, `SAB_REG_CTRL, 32'hFFFF_FFF8);
    rdc(`SAB_REG_CTRL, 32'hFFFF_FFFF, 32'h8);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `SAB_REG_CFG, cfgw(1'b1, i[2:0], 2'h3, i[1:0]));
      rdc(`SAB_REG_STATUS, 32'h01FF_C000, stx(80 - 5 * i, 5 + 2 * (i % 4)));
    end
    apb(1'b1, `SAB_REG_CFG, cfgw(1'b0, 3'h0, 2'h3, 2'h0)); wt(3);
    chk({25'h0, current_pct}, 32'h64);
    apb(1'b1, `SAB_REG_CFG, cfgw(1'b1, 3'h0, 2'h3, 2'h0));
    repeat (24) apb(1'b1, `SAB_REG_MOTOR, 32'hFFE7_FF00);
    chk({25'h0, current_pct}, 32'h50);
    load_rising <= 1'b1; apb(1'b1, `SAB_REG_MOTOR, 32'hFFE7_FF00); load_rising <= 1'b0;
    chk({25'h0, current_pct}, 32'h55);
    chk({30'h0, coil_pol}, 32'h3);
    // Step rate against limit per pin level and resolution
    if_serial <= 1'b0;
    for (int p = 0; p < 4; p++) for (int r = 0; r < 2; r++) for (int s = 0; s < 2; s++) begin
      freq_floor_pin <= p[1:0];
      apb(1'b1, `SAB_REG_CTRL, {28'h0, 1'b1, 3'(r)}); wt(30);
      per = (lims[p] >> r) + (s == 1 ? -20 : 20);
      step(3, per);
      rdc(`SAB_REG_STATUS, 32'h40, (p < 3 && s == 0) ? 32'h40 : 32'h0);
    end
    for (int k = 0; k < 8; k++) begin
      floor_sel_bit0 <= k[2]; floor_sel_bit1 <= k[1:0]; boost_level_pin <= k[1:0]; wt(30);
      rdc(`SAB_REG_STATUS, 32'h01FF_C000, stx((k > 3 ? 80 : 60) - 5 * (k % 4), 5 + 2 * (k % 4)));
    end
    // Short pulse rejected, longer one taken
    floor_sel_bit0 <= 1'b0; wt(10); floor_sel_bit0 <= 1'b1; wt(30);
    rdc(`SAB_REG_STATUS, 32'h01FF_C000, stx(65, 11));
    floor_sel_bit0 <= 1'b0; wt(18);
    rdc(`SAB_REG_STATUS, 32'h01FF_C000, stx(45, 11));
    fault(0, 2'h0, 1'b1);
    fault(1, 2'h1, 1'b0);
    fault(2, 2'h2, 1'b1);
    // Coil current must follow commanded direction
    if_serial <= 1'b1;
    apb(1'b1, `SAB_REG_MOTOR, 32'hFFE7_FF00); wt(100);
    chk({30'h0, i_coil.coil_i[1] > 0, i_coil.coil_i[0] > 0}, 32'h3);
    seen(4'h9);
    seen(4'h6);
    seen(4'h3);
    apb(1'b1, `SAB_REG_MOTOR, 32'hFFE7_FE00); wt(150);
    chk({31'h0, i_coil.coil_i[0] < 0}, 32'h1);
    stby_n <= 1'b0; wt(8);
    chk({30'h0, osc_run, gate_a == 4'h0}, 32'h1);
    stby_n <= 1'b1; wt(20);
    chk({31'h0, osc_run}, 32'h1);
    if_serial <= 1'b0; wt(30);
    rdc(`SAB_REG_STATUS, 32'h60, 32'h20);
    rst_n <= 1'b0; antistall_enable <= 1'b0; wt(3);
    rst_n <= 1'b1; wt(30);
    rdc(`SAB_REG_STATUS, 32'h60, 32'h0);
    chk({25'h0, current_pct}, 32'h64);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
